/* File: src/mac_pkg.sv */
// package of constants and types for the multiply-accumulate datapath
package mac_pkg;
	localparam int MAC_DATA_W = 16; // operand width
	localparam int MAC_PROD_W = 32; // product register width
	localparam int MAC_ACC_W = 36; // accumulator width
	localparam int MAC_ADDR_W = 11; // data memory address width
	localparam int MAC_ALIGN_SH = 16; // alignment shift of aligned variant
	localparam int MAC_EXT_W = MAC_ACC_W - MAC_PROD_W; // sign-extension bits
	// product shift field codes
	localparam logic [1:0] MAC_SHIFT_NONE = 2'h0;
	localparam logic [1:0] MAC_SHIFT_R1 = 2'h1;
	localparam logic [1:0] MAC_SHIFT_L1 = 2'h2;
	localparam logic [1:0] MAC_SHIFT_L2 = 2'h3;
	// instruction selector
	typedef enum logic [1:0] {
		MAC_OP_MAASU,
		MAC_OP_MAC,
		MAC_OP_MACSU,
		MAC_OP_MACUS
	} mac_op_t;
	// operand forms
	typedef enum logic [2:0] {
		MAC_FM_Y_PTR, // y, (address_pointer)
		MAC_FM_Y_REG, // y, register
		MAC_FM_Y_DIR, // y, direct address
		MAC_FM_PTR_PTR, // (y_memory_pointer), (x_memory_pointer)
		MAC_FM_PTR_IMM // (address_pointer), long immediate
	} mac_form_t;
	// sequencer states
	typedef enum logic [0:0] {
		MAC_ST_IDLE,
		MAC_ST_IMM
	} mac_state_t;
	// flags driven by the unit; R is kept outside
	typedef struct packed {
		logic zero;
		logic minus;
		logic norm;
		logic ovf;
		logic carry;
		logic ext;
		logic limit;
	} mac_flags_t;
	// instruction request from the decoder
	typedef struct packed {
		mac_op_t op;
		mac_form_t form;
		logic acc_sel;
	} mac_instr_t;
	// entire state of the unit
	typedef struct packed {
		mac_state_t state;
		mac_instr_t pend;
		logic [MAC_DATA_W-1:0] y;
		logic [MAC_DATA_W-1:0] x;
		logic [MAC_PROD_W-1:0] p;
		logic [MAC_ACC_W-1:0] a0;
		logic [MAC_ACC_W-1:0] a1;
		mac_flags_t flags;
		logic done;
		logic illegal;
	} mac_regs_t;
endpackage : mac_pkg

/* File: src/mac_unit.sv */
// multiply-accumulate datapath: y/x input registers, product, two accumulators
`timescale 1ns/1ps
`default_nettype none
module mac_unit (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// instruction from decoder
	input wire logic instr_valid_i,
	input wire mac_pkg::mac_instr_t instr_i,
	output logic ready_o,
	output logic done_o,
	output logic illegal_o,
	// status register one product shift field
	input wire logic [1:0] product_shift_field_i,
	// operand sources
	input wire logic [mac_pkg::MAC_DATA_W-1:0] reg_data_i,
	input wire logic [mac_pkg::MAC_DATA_W-1:0] prog_word_i,
	input wire logic [mac_pkg::MAC_ADDR_W-1:0] y_memory_pointer_i,
	input wire logic [mac_pkg::MAC_ADDR_W-1:0] x_memory_pointer_i,
	input wire logic [mac_pkg::MAC_ADDR_W-1:0] address_pointer_i,
	input wire logic [mac_pkg::MAC_ADDR_W-1:0] direct_addr_i,
	// Y-RAM read port
	output logic yram_rd_o,
	output logic [mac_pkg::MAC_ADDR_W-1:0] yram_addr_o,
	input wire logic [mac_pkg::MAC_DATA_W-1:0] yram_rdata_i,
	// X-RAM read port
	output logic xram_rd_o,
	output logic [mac_pkg::MAC_ADDR_W-1:0] xram_addr_o,
	input wire logic [mac_pkg::MAC_DATA_W-1:0] xram_rdata_i,
	// datapath state
	output logic [mac_pkg::MAC_DATA_W-1:0] y_o,
	output logic [mac_pkg::MAC_DATA_W-1:0] x_o,
	output logic [mac_pkg::MAC_PROD_W-1:0] p_o,
	output logic [mac_pkg::MAC_ACC_W-1:0] target_accumulator0_o,
	output logic [mac_pkg::MAC_ACC_W-1:0] target_accumulator1_o,
	output mac_pkg::mac_flags_t flags_o
);
	mac_pkg::mac_regs_t s_r; // registered state
	mac_pkg::mac_regs_t s_nxt; // next state
	mac_pkg::mac_instr_t ex; // instruction being executed
	logic take; // request accepted this cycle
	logic bad_form; // aligned variant with direct address
	logic exec; // accumulate and multiply this cycle
	logic y_first; // form that reuses y
	logic [mac_pkg::MAC_DATA_W-1:0] op1; // value bound for y
	logic [mac_pkg::MAC_DATA_W-1:0] op2; // value bound for x
	logic [mac_pkg::MAC_ACC_W-1:0] p_ext; // sign-extended previous product
	logic [mac_pkg::MAC_ACC_W-1:0] p_sh; // after product shift
	logic [mac_pkg::MAC_ACC_W-1:0] addend; // value added to accumulator
	logic [mac_pkg::MAC_ACC_W-1:0] acc_old; // selected accumulator
	logic [mac_pkg::MAC_ACC_W:0] sum; // sum with carry out
	logic [mac_pkg::MAC_ACC_W-1:0] res; // accumulation result
	mac_pkg::mac_flags_t flg; // flags of this result

	// signedness per instruction; 17-bit extension keeps unsigned operands positive
	function automatic logic [mac_pkg::MAC_PROD_W-1:0] mul(
		input mac_pkg::mac_op_t op,
		input logic [mac_pkg::MAC_DATA_W-1:0] yv,
		input logic [mac_pkg::MAC_DATA_W-1:0] xv
	);
		logic signed [mac_pkg::MAC_DATA_W:0] ys;
		logic signed [mac_pkg::MAC_DATA_W:0] xs;
		logic signed [2*mac_pkg::MAC_DATA_W+1:0] pr;
		ys = {(op != mac_pkg::MAC_OP_MACUS) & yv[mac_pkg::MAC_DATA_W-1], yv};
		xs = {((op == mac_pkg::MAC_OP_MAC) | (op == mac_pkg::MAC_OP_MACUS))
			& xv[mac_pkg::MAC_DATA_W-1], xv};
		pr = ys * xs;
		return pr[mac_pkg::MAC_PROD_W-1:0]; // mixed-sign products fit in 32 bits
	endfunction : mul

	// handshake and decode
	assign ready_o = (s_r.state == mac_pkg::MAC_ST_IDLE);
	assign take = instr_valid_i & ready_o;
	assign bad_form = (instr_i.op == mac_pkg::MAC_OP_MAASU)
		& (instr_i.form == mac_pkg::MAC_FM_Y_DIR);
	assign y_first = (instr_i.form == mac_pkg::MAC_FM_Y_PTR)
		| (instr_i.form == mac_pkg::MAC_FM_Y_REG)
		| (instr_i.form == mac_pkg::MAC_FM_Y_DIR);

	// memory addressing; reads are combinational in the request cycle
	always_comb begin
		yram_rd_o = take & ~bad_form & (instr_i.form == mac_pkg::MAC_FM_PTR_PTR);
		xram_rd_o = take & ~bad_form & (instr_i.form != mac_pkg::MAC_FM_Y_REG);
		yram_addr_o = y_memory_pointer_i;
		unique case (instr_i.form)
			mac_pkg::MAC_FM_PTR_PTR: xram_addr_o = x_memory_pointer_i;
			mac_pkg::MAC_FM_Y_DIR: xram_addr_o = direct_addr_i;
			default: xram_addr_o = address_pointer_i;
		endcase
	end

	// operand selection
	always_comb begin
		unique case (instr_i.form)
			mac_pkg::MAC_FM_PTR_PTR: op1 = yram_rdata_i;
			mac_pkg::MAC_FM_PTR_IMM: op1 = xram_rdata_i;
			default: op1 = s_r.y;
		endcase
		unique case (instr_i.form)
			mac_pkg::MAC_FM_Y_REG: op2 = reg_data_i;
			default: op2 = xram_rdata_i;
		endcase
	end

	// previous product path: extend, shift, optionally align
	always_comb begin
		ex = (s_r.state == mac_pkg::MAC_ST_IMM) ? s_r.pend : instr_i;
		p_ext = {{mac_pkg::MAC_EXT_W{s_r.p[mac_pkg::MAC_PROD_W-1]}}, s_r.p};
		unique case (product_shift_field_i)
			mac_pkg::MAC_SHIFT_NONE: p_sh = p_ext;
			mac_pkg::MAC_SHIFT_R1: p_sh = $unsigned($signed(p_ext) >>> 1);
			mac_pkg::MAC_SHIFT_L1: p_sh = p_ext << 1;
			mac_pkg::MAC_SHIFT_L2: p_sh = p_ext << 2;
		endcase
		if (ex.op == mac_pkg::MAC_OP_MAASU) begin
			addend = $unsigned($signed(p_sh) >>> mac_pkg::MAC_ALIGN_SH);
		end else begin
			addend = p_sh;
		end
		acc_old = ex.acc_sel ? s_r.a1 : s_r.a0;
		sum = {1'b0, acc_old} + {1'b0, addend};
		res = sum[mac_pkg::MAC_ACC_W-1:0];
	end

	// flags from the accumulation result
	always_comb begin
		flg.zero = (res == '0);
		flg.minus = res[mac_pkg::MAC_ACC_W-1];
		flg.carry = sum[mac_pkg::MAC_ACC_W];
		flg.ovf = (acc_old[mac_pkg::MAC_ACC_W-1] == addend[mac_pkg::MAC_ACC_W-1])
			& (res[mac_pkg::MAC_ACC_W-1] != acc_old[mac_pkg::MAC_ACC_W-1]);
		// extension in use when bits 35..31 disagree
		flg.ext = ~((&res[mac_pkg::MAC_ACC_W-1:mac_pkg::MAC_PROD_W-1])
			| ~(|res[mac_pkg::MAC_ACC_W-1:mac_pkg::MAC_PROD_W-1]));
		flg.norm = flg.zero | (~flg.ext & (res[mac_pkg::MAC_PROD_W-1]
			^ res[mac_pkg::MAC_PROD_W-2]));
		flg.limit = s_r.flags.limit | flg.ovf; // latches until reset
	end

	// sequencer and register updates
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.illegal = 1'b0;
		exec = 1'b0;
		unique case (s_r.state)
			mac_pkg::MAC_ST_IDLE: begin
				if (take & bad_form) begin
					s_nxt.illegal = 1'b1; // refused, no state touched
				end else if (take & (instr_i.form == mac_pkg::MAC_FM_PTR_IMM)) begin
					s_nxt.y = op1;
					s_nxt.pend = instr_i;
					s_nxt.state = mac_pkg::MAC_ST_IMM;
				end else if (take) begin
					if (!y_first) begin
						s_nxt.y = op1;
					end
					s_nxt.x = op2;
					exec = 1'b1;
				end
			end
			mac_pkg::MAC_ST_IMM: begin
				s_nxt.x = prog_word_i; // second word
				s_nxt.state = mac_pkg::MAC_ST_IDLE;
				exec = 1'b1;
			end
		endcase
		if (exec) begin
			if (ex.acc_sel) begin
				s_nxt.a1 = res;
			end else begin
				s_nxt.a0 = res;
			end
			s_nxt.flags = flg;
			s_nxt.p = mul(ex.op, s_nxt.y, s_nxt.x);
			s_nxt.done = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs from flip-flops
	assign done_o = s_r.done;
	assign illegal_o = s_r.illegal;
	assign y_o = s_r.y;
	assign x_o = s_r.x;
	assign p_o = s_r.p;
	assign target_accumulator0_o = s_r.a0;
	assign target_accumulator1_o = s_r.a1;
	assign flags_o = s_r.flags;

	// checks
	mac_pkg::mac_op_t last_op; // instruction of last completion
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			last_op <= mac_pkg::MAC_OP_MAASU;
		end else if (exec) begin
			last_op <= ex.op;
		end
	end
	sequence s_imm_take;
		take && !bad_form && instr_i.form == mac_pkg::MAC_FM_PTR_IMM;
	endsequence
	sequence s_imm_finish;
		!ready_o && !done_o ##1 ready_o && done_o;
	endsequence
	a_imm_two_cycles: assert property (@(posedge clk_i) disable iff (!resetn_i)
		s_imm_take |=> s_imm_finish) else $error("long immediate not two cycles");
	a_one_cycle: assert property (@(posedge clk_i) disable iff (!resetn_i)
		take && !bad_form && instr_i.form != mac_pkg::MAC_FM_PTR_IMM |=> done_o && ready_o)
		else $error("single cycle instruction late");
	a_y_kept: assert property (@(posedge clk_i) disable iff (!resetn_i)
		take && y_first |=> y_o == $past(y_o)) else $error("y changed on y form");
	a_product_value: assert property (@(posedge clk_i) disable iff (!resetn_i)
		done_o |-> p_o == mul(last_op, y_o, x_o)) else $error("product mismatch");
	a_aligned_refused: assert property (@(posedge clk_i) disable iff (!resetn_i)
		take && bad_form |=> illegal_o && !done_o && $stable(target_accumulator0_o)
		&& $stable(target_accumulator1_o)) else $error("direct form accepted");
	a_dual_fetch: assert property (@(posedge clk_i) disable iff (!resetn_i)
		take && instr_i.form == mac_pkg::MAC_FM_PTR_PTR |-> yram_rd_o && xram_rd_o
		&& yram_addr_o == y_memory_pointer_i && xram_addr_o == x_memory_pointer_i)
		else $error("dual fetch missing");
	a_align_add: assert property (@(posedge clk_i) disable iff (!resetn_i)
		exec && ex.op == mac_pkg::MAC_OP_MAASU
		|-> addend[mac_pkg::MAC_ACC_W-1:mac_pkg::MAC_ACC_W-mac_pkg::MAC_ALIGN_SH]
		== {mac_pkg::MAC_ALIGN_SH{p_sh[mac_pkg::MAC_ACC_W-1]}})
		else $error("alignment not sign filled");
	a_zero_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
		take && !bad_form && instr_i.form != mac_pkg::MAC_FM_PTR_IMM && !instr_i.acc_sel
		|=> flags_o.zero == (target_accumulator0_o == '0)) else $error("zero flag wrong");
	a_acc_sum: assert property (@(posedge clk_i) disable iff (!resetn_i)
		exec && ex.acc_sel |=> target_accumulator1_o == $past(acc_old) + $past(addend))
		else $error("accumulate wrong");
endmodule : mac_unit
`default_nettype wire

/* File: dv/mac_mem_model.sv */
// x/y data memory model answering reads in the same cycle
`timescale 1ns/1ps
`default_nettype none
module mac_mem_model #(
	parameter logic [15:0] SALT = 16'h0000 // content pattern of this memory
) (
	// clock
	input wire logic clk_i,
	// read port
	input wire logic rd_i,
	input wire logic [10:0] addr_i,
	output logic [15:0] rdata_o
);
	logic [15:0] last_r; // last word handed out
	// remember the last word so an idle port can show its inverse
	always_ff @(posedge clk_i) begin
		if (rd_i) last_r <= {addr_i[4:0], addr_i} ^ SALT;
	end
	// idle port never repeats a stale word, so a late sample shows up
	assign rdata_o = rd_i ? ({addr_i[4:0], addr_i} ^ SALT) : ~last_r;
endmodule : mac_mem_model
`default_nettype wire

/* File: dv/mac_unit_tb_top.sv */
// self-checking bench for the multiply-accumulate datapath
`timescale 1ns/1ps
`default_nettype none
module mac_unit_tb_top;
	// expected outcome of one request
	typedef struct {
		int cyc;
		bit ill;
		bit sel;
		logic [15:0] y;
		logic [15:0] x;
		logic [31:0] p;
		logic [35:0] a;
		mac_pkg::mac_flags_t f;
	} mac_exp_t;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic instr_valid_i = 1'b0;
	mac_pkg::mac_instr_t instr_i = '0;
	logic [1:0] product_shift_field_i = 2'h0;
	logic [15:0] reg_data_i = 16'h0000;
	logic [15:0] prog_word_i = 16'h0000;
	logic [10:0] y_memory_pointer_i = 11'h000;
	logic [10:0] x_memory_pointer_i = 11'h000;
	logic [10:0] address_pointer_i = 11'h000;
	logic [10:0] direct_addr_i = 11'h000;
	logic ready_o, done_o, illegal_o, yram_rd_o, xram_rd_o;
	logic [10:0] yram_addr_o, xram_addr_o;
	logic [15:0] yram_rdata_i, xram_rdata_i, y_o, x_o;
	logic [31:0] p_o;
	logic [35:0] target_accumulator0_o, target_accumulator1_o;
	mac_pkg::mac_flags_t flags_o;
	int n_errors = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h00000050; // xorshift state
	mac_exp_t q[$]; // notes awaiting a result
	mac_exp_t got;
	// reference copy of the datapath state
	logic [15:0] ym = 16'h0000;
	logic [15:0] xm = 16'h0000;
	logic [31:0] pm = 32'h00000000;
	logic [35:0] am [2] = '{36'h0, 36'h0};
	mac_pkg::mac_flags_t fexp = '0; // flags after the last accepted request

	mac_unit mac_unit_inst (.clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
		.instr_i(instr_i), .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o),
		.product_shift_field_i(product_shift_field_i), .reg_data_i(reg_data_i),
		.prog_word_i(prog_word_i), .y_memory_pointer_i(y_memory_pointer_i),
		.x_memory_pointer_i(x_memory_pointer_i), .address_pointer_i(address_pointer_i),
		.direct_addr_i(direct_addr_i), .yram_rd_o(yram_rd_o), .yram_addr_o(yram_addr_o),
		.yram_rdata_i(yram_rdata_i), .xram_rd_o(xram_rd_o), .xram_addr_o(xram_addr_o),
		.xram_rdata_i(xram_rdata_i), .y_o(y_o), .x_o(x_o), .p_o(p_o),
		.target_accumulator0_o(target_accumulator0_o),
		.target_accumulator1_o(target_accumulator1_o), .flags_o(flags_o));
	// the two on-core data memories
	mac_mem_model #(.SALT(16'h3C00)) mac_mem_model_y_inst (.clk_i(clk_i), .rd_i(yram_rd_o),
		.addr_i(yram_addr_o), .rdata_o(yram_rdata_i));
	mac_mem_model #(.SALT(16'hA500)) mac_mem_model_x_inst (.clk_i(clk_i), .rd_i(xram_rd_o),
		.addr_i(xram_addr_o), .rdata_o(xram_rdata_i));

	// 20 MHz clock
	initial forever #25 clk_i = ~clk_i;
	// edge counter for answer timing
	always @(posedge clk_i) cyc <= cyc + 1;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [15:0] memv(logic [10:0] a, logic [15:0] s);
		return {a[4:0], a} ^ s;
	endfunction : memv

	task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	// drive one request at a falling edge and note what must follow
	task automatic issue(int i);
		mac_exp_t e;
		mac_pkg::mac_op_t op;
		mac_pkg::mac_form_t fm;
		logic [15:0] ny, nx;
		logic [35:0] sh;
		logic signed [33:0] pr;
		logic [31:0] r;
		logic [36:0] sum;
		mac_pkg::mac_flags_t nf;
		op = mac_pkg::mac_op_t'(i % 4);
		fm = mac_pkg::mac_form_t'((i / 4) % 5);
		r = rnd();
		{reg_data_i, prog_word_i} = rnd();
		y_memory_pointer_i = r[10:0];
		x_memory_pointer_i = r[21:11];
		address_pointer_i = r[31:21];
		direct_addr_i = r[20:10];
		instr_i = '{op: op, form: fm, acc_sel: r[5]};
		product_shift_field_i = 2'(i / 20);
		instr_valid_i = 1'b1;
		// operand routing per form; y-first forms keep y
		ny = ym;
		nx = reg_data_i;
		if (fm == mac_pkg::MAC_FM_Y_PTR) nx = memv(address_pointer_i, 16'hA500);
		if (fm == mac_pkg::MAC_FM_Y_DIR) nx = memv(direct_addr_i, 16'hA500);
		if (fm == mac_pkg::MAC_FM_PTR_PTR) ny = memv(y_memory_pointer_i, 16'h3C00);
		if (fm == mac_pkg::MAC_FM_PTR_PTR) nx = memv(x_memory_pointer_i, 16'hA500);
		if (fm == mac_pkg::MAC_FM_PTR_IMM) ny = memv(address_pointer_i, 16'hA500);
		if (fm == mac_pkg::MAC_FM_PTR_IMM) nx = prog_word_i;
		// previous product widened, shifted, aligned
		sh = {{4{pm[31]}}, pm};
		if (product_shift_field_i == 2'h1) sh = $signed(sh) >>> 1;
		if (product_shift_field_i == 2'h2) sh = sh << 1;
		if (product_shift_field_i == 2'h3) sh = sh << 2;
		if (op == mac_pkg::MAC_OP_MAASU) sh = $signed(sh) >>> 16;
		// reference flags from the 36-bit accumulation; limit is sticky
		sum = {1'b0, am[r[5]]} + {1'b0, sh};
		nf.zero = sum[35:0] == 36'h0;
		nf.minus = sum[35];
		nf.carry = sum[36];
		nf.ovf = (am[r[5]][35] == sh[35]) && (sum[35] != am[r[5]][35]);
		nf.ext = (sum[35:31] != 5'h00) && (sum[35:31] != 5'h1F);
		nf.norm = nf.zero || (!nf.ext && (sum[31] != sum[30]));
		nf.limit = fexp.limit || nf.ovf;
		pr = $signed({(op == mac_pkg::MAC_OP_MACUS) ? 1'b0 : ny[15], ny})
			* $signed({(op == mac_pkg::MAC_OP_MAC || op == mac_pkg::MAC_OP_MACUS) ? nx[15] : 1'b0, nx});
		e.ill = op == mac_pkg::MAC_OP_MAASU && fm == mac_pkg::MAC_FM_Y_DIR;
		if (!e.ill) begin
			am[r[5]] = am[r[5]] + sh;
			ym = ny;
			xm = nx;
			pm = pr[31:0];
			fexp = nf;
		end
		e.cyc = cyc + ((fm == mac_pkg::MAC_FM_PTR_IMM) ? 2 : 1);
		e.sel = r[5];
		e.y = ym;
		e.x = xm;
		e.p = pm;
		e.a = am[r[5]];
		e.f = fexp;
		q.push_back(e);
		@(negedge clk_i);
		// long immediate holds the unit for a second cycle
		if (fm == mac_pkg::MAC_FM_PTR_IMM) begin
			instr_valid_i = 1'b0;
			check("ready", ready_o, 1'b0);
			@(negedge clk_i);
		end
	endtask : issue

	// main sequence: every op, form and shift code back to back
	initial begin
		repeat (12) @(negedge clk_i);
		resetn_i = 1'b1;
		check("acc0 reset", target_accumulator0_o, 36'h0);
		for (int i = 0; i < 80; i++) issue(i);
		instr_valid_i = 1'b0;
		repeat (3) @(negedge clk_i);
		check("pending", q.size(), 0);
		complete_run();
	end

	// watchdog well past the expected run length
	initial begin
		#(50 * 2000);
		n_errors++;
		complete_run();
	end

	// result watcher: oldest note against each answer
	always @(negedge clk_i) begin
		if (resetn_i && (done_o === 1'b1 || illegal_o === 1'b1) && q.size() > 0) begin
			got = q.pop_front();
			check("cycle", cyc, got.cyc);
			check("refused", illegal_o, got.ill);
			check("y", y_o, got.y);
			check("x", x_o, got.x);
			check("product", p_o, got.p);
			check("acc", got.sel ? target_accumulator1_o : target_accumulator0_o, got.a);
			check("flags", flags_o, got.f);
			if (!got.ill) begin
				check("minus", flags_o.minus, got.a[35]);
				check("zero", flags_o.zero, got.a == 36'h0);
			end
		end
	end
endmodule : mac_unit_tb_top
`default_nettype wire
